/* acl_defines.vh */
`ifndef ACL_DEFINES_VH
`define ACL_DEFINES_VH

// ==========================================================
// register byte offsets
`define OFS_CTRL       8'h00
`define OFS_SRC_LO     8'h04
`define OFS_SRC_HI     8'h08
`define OFS_DST_LO     8'h0c
`define OFS_DST_HI     8'h10
`define OFS_VLAN       8'h14
`define OFS_SPA        8'h18
`define OFS_SPA_MASK   8'h1c
`define OFS_TPA        8'h20
`define OFS_TPA_MASK   8'h24
`define OFS_STATUS     8'h28

// ==========================================================
// control register field positions
`define CTL_FT_LSB     0
`define CTL_SRC_BIT    3
`define CTL_DST_LSB    4
`define CTL_TAG_LSB    7
`define CTL_VID_BIT    9
`define CTL_PRIO_BIT   10
`define CTL_OPC_LSB    11
`define CTL_RR_LSB     13
`define CTL_SPA_LSB    15
`define CTL_TPA_LSB    17
`define CTL_SHA_LSB    19
`define CTL_THA_LSB    21
`define CTL_LEN_LSB    23
`define CTL_HRD_LSB    25
`define CTL_PRO_LSB    27
`define CTL_WIDTH      29

// vlan register field positions
`define VLAN_VID_LSB   0
`define VLAN_PRIO_LSB  12
`define VLAN_WIDTH     15

// status register field positions
`define STS_CRIT_LSB   0
`define STS_HIT_BIT    16

// ==========================================================
// reset values: every criterion reads any
`define CTRL_RST       29'h0000000
`define VLAN_RST       15'h0000

// ==========================================================
// encodings
`define FT_ANY         3'h0
`define FT_ETH         3'h1
`define FT_ARP         3'h2
`define FT_IPV4        3'h3
`define FT_IPV6        3'h4
`define DST_ANY        3'h0
`define DST_MC         3'h1
`define DST_BC         3'h2
`define DST_UC         3'h3
`define DST_SPEC       3'h4
`define TAG_ANY        2'h0
`define TAG_ON         2'h1
`define TAG_OFF        2'h2
`define OPC_ANY        2'h0
`define OPC_ARP        2'h1
`define OPC_RARP       2'h2
`define OPC_OTHER      2'h3
`define RR_ANY         2'h0
`define RR_REQ         2'h1
`define RR_REP         2'h2
`define IPF_ANY        2'h0
`define IPF_HOST       2'h1
`define IPF_NET        2'h2
`define CHK_ANY        2'h0
`define CHK_ZERO       2'h1
`define CHK_ONE        2'h2
`define CMP_ANY        2'h0
`define CMP_EXACT      2'h1
`define CMP_MASKED     2'h2

// ==========================================================
// frame header constants
`define ETYPE_MIN      16'h0600
`define ETYPE_ARP      16'h0806
`define ETYPE_RARP     16'h8035
`define ETYPE_IPV4     16'h0800
`define ETYPE_IPV6     16'h86dd
`define OP_ARP_REQ     16'h0001
`define OP_ARP_REP     16'h0002
`define OP_RARP_REQ    16'h0003
`define OP_RARP_REP    16'h0004
`define HLN_ETH        8'h06
`define PLN_IPV4       8'h04
`define HRD_ETH        16'h0001
`define PRO_IP         16'h0800

`endif

/* field_match.v */
`include "acl_defines.vh"

// ==========================================================
// one field compare: any, exact or under a mask
module field_match #(
  parameter W = 32
) (
  // selection
  input  wire [1:0]   mode,
  input  wire [W-1:0] value,
  input  wire [W-1:0] mask,
  // frame field
  input  wire [W-1:0] field,
  // result
  output reg          match
);

  always @* begin
    case (mode)
      `CMP_EXACT:  match = (field == value);
      `CMP_MASKED: match = ((field & mask) == (value & mask));
      default:     match = 1'b1;
    endcase
  end

endmodule

/* acl_entry_match.v */
// Contract
// R1: source address criterion only evaluated for ethernet-type or arp entries.
// R2: source filter any ignores address; specific needs exact equality.
// R3: destination filter: any, multicast, broadcast, unicast or specific.
// R4: specific destination filter hits only on exact destination equality.
// R5: tagged criterion any, tagged only or untagged only; resets to any.
// R6: vlan id filter any, or frame id equals configured value.
// R7: tag priority ignored or must equal configured 0 to 7.
// R8: opcode class any, arp opcode, rarp opcode, or neither.
// R9: request/reply any, request opcodes, or reply opcodes.
// R10: sender protocol address any, full compare, or masked compare.
// R11: target protocol address any, full compare, or masked compare.
// R12: arp sender hw address vs source: 0 differs, 1 equals, any ignored.
// R13: rarp target hw address vs source: 0 differs, 1 equals, any ignored.
// R14: length check 1 needs hw length 6 and protocol length 4.
// R15: hw space check 1 needs hardware type 1.
// R16: protocol space check 1 needs protocol type 0x800.
// R17: frame types exclusive; ethernet-type needs type at least 0x600, not arp.
// R18: setting 0 of length and space checks is complement of 1.
// R19: hit only when every criterion matches; any always matches.
//
// The APB interface to the registers and the register offsets were decided locally.
`include "acl_defines.vh"

module acl_entry_match (
  // clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output reg         pslverr,
  // parsed header from receive path
  input  wire        frame_valid,
  input  wire [47:0] destination_hw_address,
  input  wire [47:0] source_hw_address,
  input  wire        frame_tagged,
  input  wire [11:0] frame_vid,
  input  wire [2:0]  frame_prio,
  input  wire [15:0] frame_ethertype,
  input  wire [15:0] arp_hw_type,
  input  wire [15:0] arp_proto_type,
  input  wire [7:0]  arp_hw_len,
  input  wire [7:0]  arp_proto_len,
  input  wire [15:0] arp_opcode,
  input  wire [47:0] arp_sender_hw,
  input  wire [31:0] sender_protocol_address,
  input  wire [47:0] arp_target_hw,
  input  wire [31:0] arp_target_proto,
  // result
  output reg         hit_valid,
  output reg         hit,
  output wire [2:0]  frame_type_sel
);

  // ==========================================================
  // configuration registers
  reg  [`CTL_WIDTH-1:0]  ctrl_r;
  reg  [47:0]            src_addr_r;
  reg  [47:0]            dst_addr_r;
  reg  [`VLAN_WIDTH-1:0] vlan_r;
  reg  [31:0]            spa_r;
  reg  [31:0]            spa_mask_r;
  reg  [31:0]            tpa_r;
  reg  [31:0]            tpa_mask_r;
  reg  [15:0]            crit_last_r;
  reg                    hit_last_r;

  // ==========================================================
  // control fields
  wire [2:0]  ft_sel     = ctrl_r[`CTL_FT_LSB +: 3];
  wire        src_spec   = ctrl_r[`CTL_SRC_BIT];
  wire [2:0]  dst_sel    = ctrl_r[`CTL_DST_LSB +: 3];
  wire [1:0]  tag_sel    = ctrl_r[`CTL_TAG_LSB +: 2];
  wire        vid_spec   = ctrl_r[`CTL_VID_BIT];
  wire        prio_spec  = ctrl_r[`CTL_PRIO_BIT];
  wire [1:0]  opc_sel    = ctrl_r[`CTL_OPC_LSB +: 2];
  wire [1:0]  rr_sel     = ctrl_r[`CTL_RR_LSB +: 2];
  wire [1:0]  spa_sel    = ctrl_r[`CTL_SPA_LSB +: 2];
  wire [1:0]  tpa_sel    = ctrl_r[`CTL_TPA_LSB +: 2];
  wire [1:0]  sha_sel    = ctrl_r[`CTL_SHA_LSB +: 2];
  wire [1:0]  tha_sel    = ctrl_r[`CTL_THA_LSB +: 2];
  wire [1:0]  len_sel    = ctrl_r[`CTL_LEN_LSB +: 2];
  wire [1:0]  hrd_sel    = ctrl_r[`CTL_HRD_LSB +: 2];
  wire [1:0]  pro_sel    = ctrl_r[`CTL_PRO_LSB +: 2];
  wire [11:0] vid_val    = vlan_r[`VLAN_VID_LSB +: 12];
  wire [2:0]  prio_val   = vlan_r[`VLAN_PRIO_LSB +: 3];
  assign frame_type_sel = ft_sel;

  // ==========================================================
  // apb decode; zero wait states
  wire        apb_setup  = psel & ~penable;
  wire        apb_write  = psel & penable & pwrite;
  reg  [31:0] rd_data;
  reg         rd_hit;
  assign pready = 1'b1;
  always @* begin
    rd_hit  = 1'b1;
    rd_data = 32'h00000000;
    case (paddr)
      `OFS_CTRL:     rd_data = {3'h0, ctrl_r};
      `OFS_SRC_LO:   rd_data = src_addr_r[31:0];
      `OFS_SRC_HI:   rd_data = {16'h0000, src_addr_r[47:32]};
      `OFS_DST_LO:   rd_data = dst_addr_r[31:0];
      `OFS_DST_HI:   rd_data = {16'h0000, dst_addr_r[47:32]};
      `OFS_VLAN:     rd_data = {17'h00000, vlan_r};
      `OFS_SPA:      rd_data = spa_r;
      `OFS_SPA_MASK: rd_data = spa_mask_r;
      `OFS_TPA:      rd_data = tpa_r;
      `OFS_TPA_MASK: rd_data = tpa_mask_r;
      `OFS_STATUS:   rd_data = {15'h0000, hit_last_r, crit_last_r};
      default:       rd_hit  = 1'b0;
    endcase
  end
  // read data and error captured in setup, shown in access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (apb_setup) begin
      prdata  <= pwrite ? 32'h00000000 : rd_data;
      pslverr <= ~rd_hit;
    end
  end

  // status register is read only; writes there are dropped quietly
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r     <= `CTRL_RST; // [R5]
      src_addr_r <= 48'h000000000000;
      dst_addr_r <= 48'h000000000000;
      vlan_r     <= `VLAN_RST;
      spa_r      <= 32'h00000000;
      spa_mask_r <= 32'h00000000;
      tpa_r      <= 32'h00000000;
      tpa_mask_r <= 32'h00000000;
    end else if (apb_write) begin
      case (paddr)
        `OFS_CTRL:     ctrl_r             <= pwdata[`CTL_WIDTH-1:0];
        `OFS_SRC_LO:   src_addr_r[31:0]   <= pwdata;
        `OFS_SRC_HI:   src_addr_r[47:32]  <= pwdata[15:0];
        `OFS_DST_LO:   dst_addr_r[31:0]   <= pwdata;
        `OFS_DST_HI:   dst_addr_r[47:32]  <= pwdata[15:0];
        `OFS_VLAN:     vlan_r             <= pwdata[`VLAN_WIDTH-1:0];
        `OFS_SPA:      spa_r              <= pwdata;
        `OFS_SPA_MASK: spa_mask_r         <= pwdata;
        `OFS_TPA:      tpa_r              <= pwdata;
        `OFS_TPA_MASK: tpa_mask_r         <= pwdata;
        default:       ctrl_r             <= ctrl_r;
      endcase
    end
  end

  // ==========================================================
  // frame classification
  wire is_arp_et  = (frame_ethertype == `ETYPE_ARP);
  wire is_rarp_et = (frame_ethertype == `ETYPE_RARP);
  wire is_arp     = is_arp_et | is_rarp_et;
  wire is_ipv4    = (frame_ethertype == `ETYPE_IPV4);
  wire is_ipv6    = (frame_ethertype == `ETYPE_IPV6);
  // arp and ip frames never fall into the ethernet-type class
  wire is_eth     = (frame_ethertype >= `ETYPE_MIN) & ~is_arp & ~is_ipv4 & ~is_ipv6; // [R17]
  wire arp_entry  = (ft_sel == `FT_ARP);
  reg  type_ok;
  always @* begin
    case (ft_sel)
      `FT_ETH:  type_ok = is_eth; // [R17]
      `FT_ARP:  type_ok = is_arp;
      `FT_IPV4: type_ok = is_ipv4;
      `FT_IPV6: type_ok = is_ipv6;
      default:  type_ok = 1'b1;
    endcase
  end

  // ==========================================================
  // mac criteria
  wire src_applies = (ft_sel == `FT_ETH) | arp_entry; // [R1]
  wire src_eq;
  wire dst_eq = (destination_hw_address == dst_addr_r); // [R4]
  reg  dst_ok;

  field_match #(.W(48)) u_src (
    .mode  (src_spec ? `CMP_EXACT : `CMP_ANY), // [R2]
    .value (src_addr_r),
    .mask  (48'hffffffffffff),
    .field (source_hw_address),
    .match (src_eq)
  );

  // group bit is the lsb of the first octet on the wire
  wire dst_bc = &destination_hw_address;
  wire dst_mc = destination_hw_address[40] & ~dst_bc;
  wire dst_uc = ~destination_hw_address[40];
  always @* begin
    case (dst_sel)
      `DST_MC:   dst_ok = dst_mc; // [R3]
      `DST_BC:   dst_ok = dst_bc; // [R3]
      `DST_UC:   dst_ok = dst_uc; // [R3]
      `DST_SPEC: dst_ok = dst_eq; // [R4]
      default:   dst_ok = 1'b1;
    endcase
  end
  wire src_ok = ~src_applies | src_eq; // [R1]

  // ==========================================================
  // vlan criteria
  wire vid_ok;
  wire prio_ok;
  reg  tag_ok;
  always @* begin
    case (tag_sel)
      `TAG_ON:  tag_ok = frame_tagged; // [R5]
      `TAG_OFF: tag_ok = ~frame_tagged; // [R5]
      default:  tag_ok = 1'b1;
    endcase
  end
  field_match #(.W(12)) u_vid (
    .mode  (vid_spec ? `CMP_EXACT : `CMP_ANY), // [R6]
    .value (vid_val),
    .mask  (12'hfff),
    .field (frame_vid),
    .match (vid_ok)
  );
  field_match #(.W(3)) u_prio (
    .mode  (prio_spec ? `CMP_EXACT : `CMP_ANY), // [R7]
    .value (prio_val),
    .mask  (3'h7),
    .field (frame_prio),
    .match (prio_ok)
  );

  // ==========================================================
  // arp opcode criteria
  wire op_arp  = (arp_opcode == `OP_ARP_REQ) | (arp_opcode == `OP_ARP_REP);
  wire op_rarp = (arp_opcode == `OP_RARP_REQ) | (arp_opcode == `OP_RARP_REP);
  wire op_req  = (arp_opcode == `OP_ARP_REQ) | (arp_opcode == `OP_RARP_REQ);
  wire op_rep  = (arp_opcode == `OP_ARP_REP) | (arp_opcode == `OP_RARP_REP);
  reg  opc_ok;
  reg  rr_ok;

  always @* begin
    case (opc_sel)
      `OPC_ARP:   opc_ok = op_arp; // [R8]
      `OPC_RARP:  opc_ok = op_rarp; // [R8]
      `OPC_OTHER: opc_ok = ~op_arp & ~op_rarp; // [R8]
      default:    opc_ok = 1'b1;
    endcase
  end
  always @* begin
    case (rr_sel)
      `RR_REQ: rr_ok = op_req; // [R9]
      `RR_REP: rr_ok = op_rep; // [R9]
      default: rr_ok = 1'b1;
    endcase
  end

  // ==========================================================
  // arp protocol address criteria
  wire spa_ok;
  wire tpa_ok;
  // host and network map straight onto exact and masked compare
  field_match #(.W(32)) u_spa (
    .mode  (spa_sel), // [R10]
    .value (spa_r),
    .mask  (spa_mask_r),
    .field (sender_protocol_address),
    .match (spa_ok)
  );
  field_match #(.W(32)) u_tpa (
    .mode  (tpa_sel), // [R11]
    .value (tpa_r),
    .mask  (tpa_mask_r),
    .field (arp_target_proto),
    .match (tpa_ok)
  );

  // ==========================================================
  // arp hardware address and header checks
  wire sha_same = (arp_sender_hw == source_hw_address);
  wire tha_same = (arp_target_hw == source_hw_address);
  wire len_good = (arp_hw_len == `HLN_ETH) & (arp_proto_len == `PLN_IPV4);
  wire hrd_good = (arp_hw_type == `HRD_ETH);
  wire pro_good = (arp_proto_type == `PRO_IP);
  reg  sha_ok;
  reg  tha_ok;
  reg  len_ok;
  reg  hrd_ok;
  reg  pro_ok;
  always @* begin
    case (sha_sel)
      `CHK_ZERO: sha_ok = is_arp_et & ~sha_same; // [R12]
      `CHK_ONE:  sha_ok = is_arp_et & sha_same; // [R12]
      default:   sha_ok = 1'b1;
    endcase
  end
  always @* begin
    case (tha_sel)
      `CHK_ZERO: tha_ok = is_rarp_et & ~tha_same; // [R13]
      `CHK_ONE:  tha_ok = is_rarp_et & tha_same; // [R13]
      default:   tha_ok = 1'b1;
    endcase
  end
  // setting 0 is read as the inverse of setting 1
  always @* begin
    case (len_sel)
      `CHK_ZERO: len_ok = ~len_good; // [R18]
      `CHK_ONE:  len_ok = len_good; // [R14]
      default:   len_ok = 1'b1;
    endcase
  end
  always @* begin
    case (hrd_sel)
      `CHK_ZERO: hrd_ok = ~hrd_good; // [R18]
      `CHK_ONE:  hrd_ok = hrd_good; // [R15]
      default:   hrd_ok = 1'b1;
    endcase
  end
  always @* begin
    case (pro_sel)
      `CHK_ZERO: pro_ok = ~pro_good; // [R18]
      `CHK_ONE:  pro_ok = pro_good; // [R16]
      default:   pro_ok = 1'b1;
    endcase
  end

  // ==========================================================
  // combine; arp fields only count for an arp entry
  wire [9:0] arp_raw = {pro_ok, hrd_ok, len_ok, tha_ok, sha_ok,
                        tpa_ok, spa_ok, rr_ok, opc_ok, 1'b1};
  wire [15:0] crit;
  genvar gi;
  assign crit[0] = type_ok;
  assign crit[1] = src_ok;
  assign crit[2] = dst_ok;
  assign crit[3] = tag_ok;
  assign crit[4] = vid_ok;
  assign crit[5] = prio_ok;
  generate
    for (gi = 0; gi < 10; gi = gi + 1) begin : g_arp
      assign crit[6+gi] = ~arp_entry | arp_raw[gi];
    end
  endgenerate
  wire all_ok = &crit; // [R19]

  // ==========================================================
  // result, one cycle after frame_valid
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hit_valid   <= 1'b0;
      hit         <= 1'b0;
      crit_last_r <= 16'h0000;
      hit_last_r  <= 1'b0;
    end else begin
      hit_valid <= frame_valid;
      hit       <= frame_valid & all_ok; // [R19]
      if (frame_valid) begin
        crit_last_r <= crit;
        hit_last_r  <= all_ok;
      end
    end
  end

endmodule

/* acl_entry_match_assertions.sv */
`include "acl_defines.vh"
// ========
// port checker
module acl_entry_match_assertions (
  // clock and reset
  input wire        pclk,
  input wire        presetn,
  // apb
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire        pready,
  input wire [31:0] prdata,
  input wire        pslverr,
  // frame result
  input wire        frame_valid,
  input wire        hit_valid,
  input wire        hit,
  input wire [2:0]  frame_type_sel
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire setup = psel && !penable;
  wire mapped = (paddr <= `OFS_STATUS) && (paddr[1:0] == 2'h0);
  wire ctl_wr = psel && penable && pwrite && (paddr == `OFS_CTRL);
  // status may be read in the very cycle the result lands
  reg  last_hit_r;
  wire cur_hit = hit_valid ? hit : last_hit_r;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) last_hit_r <= 1'b0;
    else if (hit_valid) last_hit_r <= hit;
  end

  hit_latency_a: assert property (frame_valid |=> hit_valid)
    else $error("no result one cycle after a frame");
  result_pulse_a: assert property (!frame_valid |=> !hit_valid)
    else $error("result without a frame");
  hit_qual_a: assert property (!hit_valid |-> !hit)
    else $error("hit outside a result cycle");
  zero_wait_a: assert property (psel |-> pready)
    else $error("slave inserted a wait state");
  type_write_a: assert property (ctl_wr |=> frame_type_sel == $past(pwdata[2:0]))
    else $error("frame type select not taken from write");
  type_hold_a: assert property (!ctl_wr |=> $stable(frame_type_sel))
    else $error("frame type select moved without a write");
  unmapped_err_a: assert property (setup && !mapped |=> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (setup && mapped |=> !pslverr)
    else $error("mapped access refused");
  ctrl_readback_a: assert property (setup && !pwrite && paddr == `OFS_CTRL
    |=> prdata[2:0] == frame_type_sel)
    else $error("control read disagrees with frame type select");
  status_hit_a: assert property (setup && !pwrite && paddr == `OFS_STATUS
    |=> prdata[16] == $past(cur_hit))
    else $error("status hit bit stale");

  cover property (frame_valid ##1 hit);
  cover property (hit_valid && !hit);
  cover property (setup && !mapped);
endmodule

bind acl_entry_match acl_entry_match_assertions u_acl_entry_match_assertions (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
  .pslverr, .frame_valid, .hit_valid, .hit, .frame_type_sel);

/* rx_path_model.sv */
// ========
// receive path: one parsed header per cycle that send is high
module rx_path_model (
  // control
  input  wire        pclk,
  input  wire        send,
  input  wire [2:0]  kind,
  // parsed header
  output logic        frame_valid,
  output logic [47:0] destination_hw_address,
  output logic [47:0] source_hw_address,
  output logic        frame_tagged,
  output logic [11:0] frame_vid,
  output logic [2:0]  frame_prio,
  output logic [15:0] frame_ethertype,
  output logic [15:0] arp_hw_type,
  output logic [15:0] arp_proto_type,
  output logic [7:0]  arp_hw_len,
  output logic [7:0]  arp_proto_len,
  output logic [15:0] arp_opcode,
  output logic [47:0] arp_sender_hw,
  output logic [31:0] sender_protocol_address,
  output logic [47:0] arp_target_hw,
  output logic [31:0] arp_target_proto
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [47:0] SRC = 48'h0200_1122_3344;
  // fields toggle between frames so stale values never pass
  logic [47:0] junk_r = 48'h5a3c_96e1_0f87;
  wire  [383:0] junk_w = {8{junk_r}};
  always @(posedge pclk) junk_r <= ~junk_r;
  always_comb begin
    {destination_hw_address, source_hw_address, frame_tagged, frame_vid, frame_prio,
     frame_ethertype, arp_hw_type, arp_proto_type, arp_hw_len, arp_proto_len, arp_opcode,
     arp_sender_hw, sender_protocol_address, arp_target_hw, arp_target_proto} = junk_w[351:0];
    frame_valid = send;
    if (send) begin
      // base: untagged broadcast arp request, well formed
      {destination_hw_address, source_hw_address} = {48'hffff_ffff_ffff, SRC};
      {frame_tagged, frame_vid, frame_prio, frame_ethertype} = {1'b0, 12'h005, 3'h3, 16'h0806};
      {arp_hw_type, arp_proto_type, arp_hw_len, arp_proto_len} = 48'h0001_0800_0604;
      {arp_opcode, arp_sender_hw, arp_target_hw} = {16'h0001, SRC, 48'h0};
      {sender_protocol_address, arp_target_proto} = 64'h0a00_0001_0a00_0002;
      case (kind)
        3'h1: begin
          {frame_ethertype, arp_opcode, frame_tagged} = {32'h8035_0004, 1'b1};
          {destination_hw_address, arp_target_hw} = {48'h0200_aabb_ccdd, SRC};
          {arp_sender_hw, arp_target_proto} = {48'h0, 32'h0a00_00fe};
        end
        3'h2: begin
          {frame_ethertype, frame_tagged, frame_vid, frame_prio} = {16'h88b5, 1'b1, 12'h006, 3'h2};
          destination_hw_address = 48'h0100_5e00_0001;
        end
        3'h3: {frame_ethertype, destination_hw_address} = {16'h0800, 48'h0200_0000_0099};
        3'h5: frame_ethertype = 16'h86dd;
        3'h4: begin
          {arp_opcode, arp_hw_len, arp_hw_type, arp_proto_type} = 56'h0007_08_0006_86dd;
          {source_hw_address, arp_sender_hw} = {48'h0200_0000_0077, 48'h0200_0000_0001};
          {sender_protocol_address, arp_target_proto} = 64'h0a00_0077_0b00_0002;
        end
        default: ;
      endcase
    end
  end
endmodule

/* acl_entry_match_tb.sv */
`include "acl_defines.vh"
module acl_entry_match_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, send = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, rd, r_ctrl[$];
  logic [2:0]  kind = 0, frame_type_sel, frame_prio, r_kind[$];
  logic        pready, pslverr, hit_valid, hit, frame_valid, frame_tagged, er, r_exp[$];
  logic [31:0] prdata, sender_protocol_address, arp_target_proto;
  logic [47:0] destination_hw_address, source_hw_address, arp_sender_hw, arp_target_hw;
  logic [15:0] frame_ethertype, arp_hw_type, arp_proto_type, arp_opcode;
  logic [11:0] frame_vid;
  logic [7:0]  arp_hw_len, arp_proto_len;
  int          num_errors = 0, check_count = 0;
  localparam logic [31:0] A = 32'(`FT_ARP);

  acl_entry_match u_acl_entry_match (.*);
  rx_path_model u_rx_path_model (.*);

  always #2 pclk = ~pclk;
  initial begin
    #100000;
    num_errors++;
    finish_test();
  end

  // ========
  // shared tasks
  function automatic logic [31:0] f(input int lsb, input int v);
    return 32'(v) << lsb;
  endfunction
  task automatic r(input logic [31:0] c, input logic [2:0] k, input logic e);
    r_ctrl.push_back(c);
    r_kind.push_back(k);
    r_exp.push_back(e);
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    // no wait limit here; the watchdog ends a hung slave
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic frame(input logic [2:0] k, input logic e);
    @(posedge pclk);
    {send, kind} <= {1'b1, k};
    @(posedge pclk);
    send <= 1'b0;
    #1;
    chk(hit_valid, 1);
    chk(hit, e);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // ========
  // sequence
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, `OFS_CTRL, 0);
    chk(rd, 0);
    apb(1, `OFS_SRC_LO, 32'h1122_3344);
    apb(1, `OFS_SRC_HI, 32'h0200);
    apb(1, `OFS_DST_LO, 32'haabb_ccdd);
    apb(1, `OFS_DST_HI, 32'h0200);
    apb(1, `OFS_VLAN, 32'h3005);
    apb(1, `OFS_SPA, 32'h0a00_0001);
    apb(1, `OFS_SPA_MASK, 32'hffff_ff00);
    apb(1, `OFS_TPA, 32'h0a00_0002);
    apb(1, `OFS_TPA_MASK, 32'hffff_ff00);
    apb(0, `OFS_SRC_LO, 0);
    chk(rd, 32'h1122_3344);
    r(0, 0, 1);
    r(`FT_ARP, 0, 1); r(`FT_ARP, 2, 0); r(`FT_ETH, 2, 1); r(`FT_ETH, 0, 0); r(`FT_ETH, 3, 0);
    r(`FT_IPV4, 3, 1); r(`FT_IPV4, 0, 0); r(`FT_IPV6, 5, 1);
    r(`FT_IPV6, 3, 0); r(`FT_ETH, 5, 0);
    r(`FT_ETH | f(3, 1), 2, 1); r(A | f(3, 1), 4, 0); r(f(3, 1), 4, 1);
    r(f(4, 1), 2, 1); r(f(4, 1), 0, 0); r(f(4, 2), 0, 1); r(f(4, 2), 1, 0);
    r(f(4, 3), 1, 1); r(f(4, 3), 2, 0); r(f(4, 4), 1, 1); r(f(4, 4), 3, 0);
    r(f(7, 1), 1, 1); r(f(7, 1), 0, 0); r(f(7, 2), 0, 1); r(f(7, 2), 1, 0);
    r(f(9, 1), 1, 1); r(f(9, 1), 2, 0); r(f(10, 1), 1, 1); r(f(10, 1), 2, 0);
    r(A | f(11, 1), 0, 1); r(A | f(11, 1), 1, 0); r(A | f(11, 2), 1, 1);
    r(A | f(11, 3), 4, 1); r(A | f(11, 3), 0, 0);
    r(A | f(13, 1), 0, 1); r(A | f(13, 1), 1, 0); r(A | f(13, 2), 1, 1);
    r(A | f(15, 1), 0, 1); r(A | f(15, 1), 4, 0); r(A | f(15, 2), 4, 1);
    r(A | f(17, 1), 0, 1); r(A | f(17, 2), 4, 0); r(A | f(17, 2), 1, 1);
    r(A | f(19, 2), 0, 1); r(A | f(19, 1), 0, 0); r(A | f(19, 1), 4, 1);
    r(A | f(21, 2), 1, 1); r(A | f(21, 1), 1, 0); r(A | f(21, 1), 0, 0);
    for (int s = 23; s <= 25; s += 2) begin
      r(A | f(s, 2), 0, 1); r(A | f(s, 2), 4, 0); r(A | f(s, 1), 4, 1);
    end
    r(A | f(27, 2), 0, 1); r(A | f(27, 2), 4, 0); r(A | f(27, 1), 0, 0);
    rd = A | f(3, 1) | f(4, 2) | f(7, 2) | f(11, 1) | f(13, 1) | f(15, 1) | f(19, 2) | f(23, 2);
    r(rd, 0, 1); r(rd | f(25, 1), 0, 0);
    foreach (r_ctrl[i]) begin
      apb(1, `OFS_CTRL, r_ctrl[i]);
      #1;
      chk(frame_type_sel, r_ctrl[i][2:0]);
      frame(r_kind[i], r_exp[i]);
    end
    $display("table of %0d rows done", r_ctrl.size());
    // status bit follows the last result; writes there are dropped quietly
    apb(1, `OFS_CTRL, A);
    frame(0, 1);
    apb(0, `OFS_STATUS, 0);
    chk(rd[16], 1);
    frame(2, 0);
    apb(1, `OFS_STATUS, 32'hffff_ffff);
    chk(er, 0);
    apb(0, `OFS_STATUS, 0);
    chk(rd[16], 0);
    apb(1, 8'h2c, 32'h1);
    chk(er, 1);
    apb(0, 8'h2c, 0);
    chk(er, 1);
    chk(rd, 0);
    $display("status and refusal done");
    // frames on consecutive cycles
    @(posedge pclk);
    {send, kind} <= {1'b1, 3'h0};
    @(posedge pclk);
    kind <= 3'h2;
    #1;
    chk(hit, 1);
    @(posedge pclk);
    send <= 1'b0;
    #1;
    chk({hit_valid, hit}, 2'b10);
    @(posedge pclk);
    #1;
    chk(hit_valid, 0);
    $display("back to back done");
    // reset in mid-run returns every criterion to any
    @(posedge pclk);
    presetn <= 1'b0;
    #1;
    chk({hit_valid, frame_type_sel}, 0);
    @(posedge pclk);
    presetn <= 1'b1;
    apb(0, `OFS_CTRL, 0);
    chk(rd, 0);
    frame(4, 1);
    $display("mid-run reset done");
    finish_test();
  end
endmodule
